/* core/swg_link.sv */
// Device-side bit engine for the single-wire gauge host link
// Functional notes
// RULE_01 - Host bit windows last at least 190 us
// RULE_02 - Reply starts 190 to 320 us after command
// RULE_03 - Device bit window 190 to 260 us
// RULE_04 - Device one: low 32 to 50 us
// RULE_05 - Device zero: low 80 to 145 us
// RULE_06 - Line held low enters sleep state
// RULE_07 - Nominal 5 kbit/s both directions; the device bit window is 220 us, about 4.5 kbit/s
// RULE_08 - Break resets receiver; bits timed by low width
`timescale 1ns/1ps
module swg_link
	import swg_pkg::*;
(
	// Clock, reset, enable
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// Single-wire line, open drain
	input wire logic i_single_wire_host_line,
	output logic o_single_wire_host_line_oe,
	output logic o_single_wire_host_line_out,
	// Received bytes
	output logic [7:0] o_rx_data,
	output logic o_rx_valid,
	output logic o_break,
	// Reply bytes to send
	input wire logic [7:0] i_tx_data,
	input wire logic i_tx_valid,
	output logic o_tx_ready,
	output logic o_tx_busy,
	// Power state
	output logic o_sleep
);
	// Line synchroniser
	logic [2:0] sync_q;
	logic line_q;
	wire line_s2 = sync_q[1];
	wire line_s3 = sync_q[2];
	wire agree = (line_s2 == line_s3);
	wire fall = agree && line_q && !line_s2;
	wire rise = agree && !line_q && line_s2;

	// Receiver
	logic [CNT_W-1:0] low_cnt_q;
	logic [2:0] rx_bit_q;
	logic [7:0] rx_sh_q;
	logic rx_valid_q;
	logic break_q;
	logic sleep_q;
	logic [7:0] rx_data_q;
	wire [CNT_W-1:0] low_inc = (low_cnt_q == '1) ? low_cnt_q : low_cnt_q + CNT_W'(1);
	wire is_break = (low_cnt_q >= BREAK_CYC); // [RULE_08]
	wire rx_bit_val = (low_cnt_q < ONE_ZERO_SPLIT_CYC); // [RULE_08]
	wire [7:0] rx_next = {rx_bit_val, rx_sh_q[7:1]};

	// Transmitter with input buffer
	swg_stream_if tx_in ();
	swg_stream_if tx_buf ();
	assign tx_in.data = i_tx_data;
	assign tx_in.valid = i_tx_valid;
	swg_skid_buf u_buf
	(
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.s_in(tx_in.snk),
		.s_out(tx_buf.src)
	);

	swg_tx_state_t st_q;
	swg_tx_state_t st_d;
	logic [CNT_W-1:0] tcnt_q;
	logic [7:0] tx_sh_q;
	logic [2:0] tx_bit_q;
	logic drive_q;
	logic tx_ready_q;
	logic busy_q;
	// A byte is only taken while idle and a reply is owed
	logic reply_due_q;
	wire take = (st_q == ST_IDLE) && reply_due_q && tx_buf.valid;
	assign tx_buf.ready = take;
	wire [CNT_W-1:0] low_len = tx_sh_q[0] ? DEV_ONE_CYC : DEV_ZERO_CYC; // [RULE_04] [RULE_05]
	wire delay_done = (tcnt_q >= REPLY_DELAY_CYC); // [RULE_02]
	wire low_done = (tcnt_q >= low_len);
	wire win_done = (tcnt_q >= DEV_WINDOW_CYC); // [RULE_03] [RULE_07]
	wire last_bit = (tx_bit_q == BIT_LAST);

	always_comb
	begin
		st_d = st_q;
		unique case (st_q)
			ST_IDLE: if (take) st_d = ST_DELAY;
			ST_DELAY: if (delay_done) st_d = ST_LOW;
			ST_LOW: if (low_done) st_d = ST_HIGH;
			ST_HIGH: if (win_done) st_d = last_bit ? ST_IDLE : ST_LOW;
			default: st_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sync_q <= 3'h7;
			line_q <= 1'b1;
		end
		else if (i_ce)
		begin
			sync_q <= {sync_q[1:0], i_single_wire_host_line};
			if (agree)
				line_q <= line_s2;
		end
	end

	// Receiver decode; own replies are not fed back into the receiver
	wire rx_edge = rise && (st_q == ST_IDLE);
	wire rx_brk = rx_edge && is_break; // [RULE_08]
	wire rx_dat = rx_edge && !is_break;
	wire rx_done = rx_dat && (rx_bit_q == BIT_LAST);
	wire sleep_set = !line_q && (low_cnt_q >= SLEEP_CYC); // [RULE_06]

	// Low-time counter and sleep flag
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			low_cnt_q <= '0;
			sleep_q <= 1'b0;
		end
		else if (i_ce)
		begin
			if (fall)
				low_cnt_q <= '0;
			else if (!line_q)
				low_cnt_q <= low_inc;
			// Sleep is only left once the line is seen high again
			if (sleep_set)
				sleep_q <= 1'b1; // [RULE_06]
			else if (line_q)
				sleep_q <= 1'b0;
		end
	end

	// Byte assembly, LSB first
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rx_bit_q <= 3'h0;
			rx_sh_q <= 8'h00;
		end
		else if (i_ce)
		begin
			if (rx_brk)
				rx_bit_q <= 3'h0; // [RULE_08]
			else if (rx_dat)
			begin
				// Host window minimum is the host's duty; bits are taken per low pulse [RULE_01]
				rx_sh_q <= rx_next;
				rx_bit_q <= rx_bit_q + 3'h1;
			end
		end
	end

	// Pulses, held byte and the owed-reply flag
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rx_valid_q <= 1'b0;
			break_q <= 1'b0;
			reply_due_q <= 1'b0;
			rx_data_q <= 8'h00;
		end
		else if (i_ce)
		begin
			rx_valid_q <= rx_done;
			break_q <= rx_brk; // [RULE_08]
			// Held copy so the output stands while the next byte shifts in
			if (rx_done)
				rx_data_q <= rx_next;
			if (rx_brk)
				reply_due_q <= 1'b0;
			else if (rx_done)
				reply_due_q <= 1'b1;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			st_q <= ST_IDLE;
			tcnt_q <= '0;
			tx_sh_q <= 8'h00;
			tx_bit_q <= 3'h0;
			drive_q <= 1'b0;
			tx_ready_q <= 1'b0;
			busy_q <= 1'b0;
		end
		else if (i_ce)
		begin
			st_q <= st_d;
			tx_ready_q <= tx_in.ready;
			if (st_q != st_d && st_d != ST_HIGH)
				tcnt_q <= '0;
			else
				tcnt_q <= tcnt_q + CNT_W'(1);
			if (take)
			begin
				tx_sh_q <= tx_buf.data;
				tx_bit_q <= 3'h0;
			end
			if (st_q == ST_HIGH && win_done && !last_bit)
			begin
				tx_sh_q <= {1'b0, tx_sh_q[7:1]};
				tx_bit_q <= tx_bit_q + 3'h1;
			end
			drive_q <= (st_d == ST_LOW); // [RULE_04] [RULE_05]
			busy_q <= (st_d != ST_IDLE);
		end
	end

	assign o_single_wire_host_line_oe = drive_q;
	assign o_single_wire_host_line_out = 1'b0;
	assign o_rx_data = rx_data_q;
	assign o_rx_valid = rx_valid_q;
	assign o_break = break_q;
	assign o_tx_ready = tx_ready_q;
	assign o_tx_busy = busy_q;
	assign o_sleep = sleep_q;
endmodule

/* common/swg_pkg.sv */
// Shared constants and types for the single-wire gauge link engine
package swg_pkg;
	localparam int unsigned CLK_MHZ = 25;
	// Host-side timing, microseconds
	localparam int unsigned BREAK_MIN_US = 190;
	localparam int unsigned BREAK_RECOVERY_US = 40;
	localparam int unsigned HOST_BIT_WINDOW_US = 190;
	localparam int unsigned HOST_ONE_LOW_MAX_US = 50;
	localparam int unsigned HOST_ZERO_LOW_MIN_US = 86;
	// Device-side timing, microseconds (chosen inside the allowed ranges)
	localparam int unsigned REPLY_START_DELAY_US = 250;
	localparam int unsigned DEVICE_BIT_WINDOW_US = 220;
	localparam int unsigned DEVICE_ONE_LOW_US = 40;
	localparam int unsigned DEVICE_ZERO_LOW_US = 110;
	// Low held this long means host power is gone; well clear of any break
	localparam int unsigned SLEEP_LOW_US = 500;
	localparam int unsigned CNT_W = 16;
	localparam logic [CNT_W-1:0] BREAK_CYC = CNT_W'(BREAK_MIN_US * CLK_MHZ);
	localparam logic [CNT_W-1:0] ONE_ZERO_SPLIT_CYC =
		CNT_W'(((HOST_ONE_LOW_MAX_US + HOST_ZERO_LOW_MIN_US) / 2) * CLK_MHZ);
	localparam logic [CNT_W-1:0] REPLY_DELAY_CYC = CNT_W'(REPLY_START_DELAY_US * CLK_MHZ);
	localparam logic [CNT_W-1:0] DEV_WINDOW_CYC = CNT_W'(DEVICE_BIT_WINDOW_US * CLK_MHZ);
	localparam logic [CNT_W-1:0] DEV_ONE_CYC = CNT_W'(DEVICE_ONE_LOW_US * CLK_MHZ);
	localparam logic [CNT_W-1:0] DEV_ZERO_CYC = CNT_W'(DEVICE_ZERO_LOW_US * CLK_MHZ);
	localparam logic [CNT_W-1:0] SLEEP_CYC = CNT_W'(SLEEP_LOW_US * CLK_MHZ);
	localparam int unsigned BYTE_W = 8;
	localparam logic [2:0] BIT_LAST = 3'h7;
	typedef enum logic [3:0]
	{
		ST_IDLE = 4'h1,
		ST_DELAY = 4'h2,
		ST_LOW = 4'h4,
		ST_HIGH = 4'h8
	} swg_tx_state_t;
endpackage

/* common/swg_stream_if.sv */
// Byte stream carrier between the link engine and its skid buffer
`timescale 1ns/1ps
interface swg_stream_if;
	logic [7:0] data;
	logic valid;
	logic ready;
	modport src
	(
		output data,
		output valid,
		input ready
	);
	modport snk
	(
		input data,
		input valid,
		output ready
	);
endinterface

/* core/swg_skid_buf.sv */
// Two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
module swg_skid_buf
	import swg_pkg::*;
(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// Ports
	swg_stream_if.snk s_in,
	swg_stream_if.src s_out
);
	logic [7:0] mem_q [2];
	logic wp_q;
	logic rp_q;
	logic [1:0] cnt_q;
	wire push = s_in.valid && s_in.ready;
	wire pop = s_out.valid && s_out.ready;
	assign s_in.ready = (cnt_q != 2'h2);
	assign s_out.valid = (cnt_q != 2'h0);
	assign s_out.data = mem_q[rp_q];
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wp_q <= 1'b0;
			rp_q <= 1'b0;
			cnt_q <= 2'h0;
			mem_q[0] <= 8'h00;
			mem_q[1] <= 8'h00;
		end
		else if (i_ce)
		begin
			if (push)
			begin
				mem_q[wp_q] <= s_in.data;
				wp_q <= ~wp_q;
			end
			if (pop)
				rp_q <= ~rp_q;
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule

/* testbench/swg_link_asserts.sv */
// Timing checks on the link engine pins
`timescale 1ns/1ps
module swg_link_asserts
(
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_single_wire_host_line,
	input wire logic o_single_wire_host_line_oe,
	input wire logic o_rx_valid,
	input wire logic o_break,
	input wire logic o_sleep
);
	logic [15:0] lo_q, ln_q, win_q, rv_q;
	logic owed_q, oe_q;
	wire logic oe = o_single_wire_host_line_oe;
	wire logic ln = i_single_wire_host_line;
	wire logic rise = oe & !oe_q;
	// Counters other than lo_q saturate so long idle never wraps
	always_ff @(posedge i_mclk or negedge i_rst_n)
		if (!i_rst_n)
		begin
			{lo_q, ln_q, win_q, rv_q, owed_q, oe_q} <= '0;
		end
		else
		begin
			oe_q <= oe;
			lo_q <= oe ? lo_q + 16'h1 : 16'h0;
			ln_q <= ln ? 16'h0 : ln_q + {15'h0, ~&ln_q};
			win_q <= rise ? 16'h1 : win_q + {15'h0, ~&win_q};
			rv_q <= o_rx_valid ? 16'h0 : rv_q + {15'h0, ~&rv_q};
			owed_q <= o_rx_valid | (owed_q & !rise & !o_break);
		end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	sequence s_brk;
		!ln && ln_q >= 16'd4800 ##1 ln;
	endsequence
	a_break_pulse: assert property (s_brk |-> ##[0:8] o_break) else $error("break missed");
	a_reply_delay: assert property (rise && owed_q |-> rv_q >= 16'd4750 && rv_q <= 16'd7990)
		else $error("reply delay");
	a_bit_window: assert property (rise && !owed_q && win_q < 16'd7000 |-> win_q >= 16'd4750 && win_q <= 16'd6500)
		else $error("bit window");
	a_one_low: assert property (!oe && oe_q && lo_q < 16'd1600 |-> lo_q >= 16'd800 && lo_q <= 16'd1250)
		else $error("one low");
	a_zero_low: assert property (!oe && oe_q && lo_q >= 16'd1600 |-> lo_q >= 16'd2000 && lo_q <= 16'd3625)
		else $error("zero low");
	a_sleep_entry: assert property (ln_q >= 16'd12600 |-> o_sleep) else $error("no sleep");
	a_sleep_exit: assert property ($rose(ln) |-> ##[1:8] !o_sleep) else $error("sleep stuck");
endmodule
bind swg_link swg_link_asserts swg_link_asserts_i (.i_mclk, .i_rst_n, .i_single_wire_host_line,
	.o_single_wire_host_line_oe, .o_rx_valid, .o_break, .o_sleep);

/* testbench/swg_host_model.sv */
// Behavioural host on the single-wire line
`timescale 1ns/1ps
module swg_host_model
(
	input wire logic i_mclk,
	input wire logic i_line,
	output logic o_oe
);
	int cnt = 0;
	bit mine = 0;
	bit got[$];
	initial o_oe = 0;
	task automatic low(input int n, input int tot);
		@(posedge i_mclk);
		#1 o_oe = 1;
		repeat (n) @(posedge i_mclk);
		#1 o_oe = 0;
		repeat (tot - n) @(posedge i_mclk);
	endtask
	task automatic put(input logic [7:0] d);
		for (int i = 0; i < 8; i++)
			low(d[i] ? 500 : 2750, 4760);
	endtask
	// Device bits judged by low width, split between the one and zero ranges
	always @(posedge i_mclk)
		if (!i_line)
		begin
			cnt++;
			mine |= o_oe;
		end
		else if (cnt > 0)
		begin
			if (!mine)
				got.push_back(cnt < 1625);
			cnt = 0;
			mine = 0;
		end
endmodule

/* testbench/tb.sv */
// Self-checking bench for the link engine
`timescale 1ns/1ps
module tb;
	logic i_mclk = 0, i_rst_n = 0, tx_v = 0, oe, rv, brk, slp, rdy, h_oe, brk_s = 0, slp_s = 0, bsy, lout;
	logic [7:0] tx_d = 0, rx_d, rx_got = 0, sent;
	wire logic line = !(oe | h_oe);
	integer seed = 90, fails = 0, tests_run = 0, i;
	bit exp[$];
	always #20 i_mclk = !i_mclk;
	swg_link swg_link_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_single_wire_host_line(line),
		.o_single_wire_host_line_oe(oe), .o_single_wire_host_line_out(lout), .o_rx_data(rx_d), .o_rx_valid(rv),
		.o_break(brk), .i_tx_data(tx_d), .i_tx_valid(tx_v), .o_tx_ready(rdy), .o_tx_busy(bsy), .o_sleep(slp));
	swg_host_model swg_host_model_i (.i_mclk(i_mclk), .i_line(line), .o_oe(h_oe));
	always @(posedge i_mclk)
	begin
		if (rv === 1'b1)
			rx_got <= rx_d;
		brk_s <= brk_s | (brk === 1'b1);
		slp_s <= slp_s | (slp === 1'b1);
	end
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e)
		begin
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
			fails++;
		end
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(posedge i_mclk);
		#1 i_rst_n = 1;
		tx_d = 8'($random(seed));
		sent = 8'($random(seed));
		for (i = 0; i < 8; i++)
			exp.push_back(tx_d[i]);
		repeat (2) @(posedge i_mclk);
		#1 tx_v = 1;
		chk("tx ready", 8'h1, 8'(rdy));
		chk("line out", 8'h0, 8'(lout));
		@(posedge i_mclk);
		#1 tx_v = 0;
		chk("early sleep", 8'h0, 8'(slp_s));
		// Long low sleeps the device; its release then counts as a break
		swg_host_model_i.low(12800, 13800);
		chk("sleep", 8'h1, 8'(slp_s));
		chk("wake", 8'h0, 8'(slp));
		chk("break", 8'h1, 8'(brk_s));
		chk("idle", 8'h0, 8'(bsy));
		$display("sleep and break test done");
		swg_host_model_i.put(sent);
		chk("rx byte", sent, rx_got);
		chk("busy", 8'h1, 8'(bsy));
		$display("receive test done");
		for (i = 0; i < 50000 && swg_host_model_i.got.size() < 8; i++)
			@(posedge i_mclk);
		if (swg_host_model_i.got.size() < 8)
		begin
			$display("CHECK FAILED reply bits exp 8 got %0d", swg_host_model_i.got.size());
			fails++;
		end
		else
			for (i = 0; i < 8; i++)
				chk("reply bit", 8'(exp[i]), 8'(swg_host_model_i.got[i]));
		$display("reply test done");
		stop_test;
	end
endmodule
